//--- common/fdar_pkg.sv
package fdar_pkg;

  localparam int NCH = 4;

  // register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00; // output commands, one bit per output
  localparam logic [7:0] OFF_CFG = 8'h04; // per-output disables and selects
  localparam logic [7:0] OFF_GCR = 8'h08; // global sense / pwm / supply-fail
  localparam logic [7:0] OFF_STAT = 8'h0C; // latched flags, read clears
  localparam logic [7:0] OFF_DIAG = 8'h10; // diagnostic register, prewarning
  localparam logic [7:0] OFF_LIVE = 8'h14; // live state, retry counters

  // cfg field positions, each a 4-bit per-output group
  localparam int CFG_SD_DIS = 0;
  localparam int CFG_OFFOL_DIS = 4;
  localparam int CFG_ONOL_DIS = 8;
  localparam int CFG_LED_SEL = 12;
  localparam int CFG_RATIO = 16;
  // gcr field positions
  localparam int GCR_TEMP_EN = 0;
  localparam int GCR_SENSE_EN = 1;
  localparam int GCR_CHSEL = 2;
  localparam int GCR_PWM_EN = 4;
  localparam int GCR_FAIL_EN = 5;
  // stat field positions
  localparam int ST_OVERCUR = 0;
  localparam int ST_OVERTEMP = 4;
  localparam int ST_SHORT = 8;
  localparam int ST_OFFOL = 12;
  localparam int ST_ONOL = 16;
  localparam int ST_UNDERVOLT = 20;

  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [4:0] RETRY_MAX = 5'h10; // attempts per output
  localparam logic [7:0] LED_FULL_DUTY = 8'hFF;

  // timing
  localparam int CLK_MHZ = 250;
  localparam int T_RETRY_US = 100;
  localparam int T_LEDCHK_US = 100;
  localparam int RETRY_CYC = T_RETRY_US * CLK_MHZ;
  localparam int LEDCHK_CYC = T_LEDCHK_US * CLK_MHZ;

  // analog-side status inputs, all per output except shared
  typedef struct packed {
    logic [NCH-1:0] overcurrent;
    logic [NCH-1:0] overtemp;
    logic [NCH-1:0] short_supply;
    logic [NCH-1:0] off_openload;
    logic [NCH-1:0] on_lowcurrent;
    logic undervoltage;
    logic temp_warn;
    logic clamp;
    logic logic_supply_ok;
    logic batt_ok;
    logic por;
    logic fail_safe;
  } fdar_sense_s;

  // sense routing output
  typedef struct packed {
    logic current_on;
    logic temp_on;
    logic [1:0] channel;
    logic ratio;
  } fdar_route_s;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_TRY, ST_LATCHED} fdar_retry_e;

endpackage

//--- logic/fdar_top.sv
`timescale 1ns/1ps
// What this block does
// - retry request from overcurrent, overtemp or undervoltage
// - retry each period, sixteen attempts max
// - retry counter cleared on mode change
// - retry restores default inrush overcurrent profile
// - short latches short and off-openload flags
// - short flag clears on read if gone
// - short-detect disable suppresses short detection
// - off openload latches, clears on read after gone
// - off-openload disable suppresses detection
// - low on-current sets flag, output stays on
// - led check each period at full duty
// - on openload held until gone and read
// - sense routed by bits, current only when on
// - prewarning latched in normal mode, read clears
// - clamp cancels turn-off, all outputs on
// - supply fail with enable resets registers
// - no logic supply: outputs follow direct inputs
// - battery loss keeps config, reports undervoltage
// - power-on reset clears registers and faults
// - overtemp and overcurrent flags clear on read
module fdar_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire fdar_pkg::fdar_sense_s sense_in,
  input wire logic [fdar_pkg::NCH-1:0] direct_in,
  input wire logic [7:0] pwm_duty,
  output logic [fdar_pkg::NCH-1:0] switch_output,
  output logic [fdar_pkg::NCH-1:0] inrush_profile,
  output logic fault_status_pin,
  output fdar_pkg::fdar_route_s sense_output
);
  import fdar_pkg::*;

  // two-flop synchroniser for analog status
  fdar_sense_s s1_q, s2_q;
  logic [NCH-1:0] din1_q, din_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      din1_q <= '0;
      din_q <= '0;
    end else begin
      s1_q <= sense_in;
      s2_q <= s1_q;
      din1_q <= direct_in;
      din_q <= din1_q;
    end
  end

  // supply resets: por always, logic-supply loss when enabled
  logic [31:0] gcr_q;
  logic sup_rst;
  assign sup_rst = s2_q.por
    || (!s2_q.logic_supply_ok && gcr_q[GCR_FAIL_EN]);

  // ahb-lite address phase capture
  logic wr_ph_q, rd_ph_q;
  logic [7:0] addr_q;
  logic take;
  assign take = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_q <= 1'b0;
      rd_ph_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_ph_q <= take && hwrite;
      rd_ph_q <= take && !hwrite;
      addr_q <= haddr[7:0];
    end
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  logic stat_rd, diag_rd;
  assign stat_rd = rd_ph_q && hit(addr_q, OFF_STAT);
  assign diag_rd = rd_ph_q && hit(addr_q, OFF_DIAG);

  // config registers; kept on battery loss, cleared by supply reset
  logic [31:0] cmd_q, cfg_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_q <= REG_RESET;
      cfg_q <= REG_RESET;
      gcr_q <= REG_RESET;
    end else if (sup_rst) begin
      cmd_q <= REG_RESET;
      cfg_q <= REG_RESET;
      gcr_q <= REG_RESET;
    end else if (wr_ph_q) begin
      if (hit(addr_q, OFF_CMD)) cmd_q <= {28'h0, hwdata[3:0]};
      if (hit(addr_q, OFF_CFG)) cfg_q <= {12'h0, hwdata[19:0]};
      if (hit(addr_q, OFF_GCR)) gcr_q <= {26'h0, hwdata[5:0]};
    end
  end

  logic [NCH-1:0] cmd, sd_dis, offol_dis, onol_dis, led_sel, ratio;
  assign cmd = cmd_q[NCH-1:0];
  assign sd_dis = cfg_q[CFG_SD_DIS +: NCH];
  assign offol_dis = cfg_q[CFG_OFFOL_DIS +: NCH];
  assign onol_dis = cfg_q[CFG_ONOL_DIS +: NCH];
  assign led_sel = cfg_q[CFG_LED_SEL +: NCH];
  assign ratio = cfg_q[CFG_RATIO +: NCH];

  // command toggle detect
  logic [NCH-1:0] cmd_prev_q;
  logic safe_prev_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_prev_q <= '0;
      safe_prev_q <= 1'b0;
    end else begin
      cmd_prev_q <= cmd;
      safe_prev_q <= s2_q.fail_safe;
    end
  end
  logic mode_chg;
  assign mode_chg = safe_prev_q != s2_q.fail_safe;

  // latched status flags; set wins over read-clear
  logic [31:0] stat_q;
  logic [NCH-1:0] ovc_f, ovt_f, sh_f, offol_f, onol_f;
  assign ovc_f = stat_q[ST_OVERCUR +: NCH];
  assign ovt_f = stat_q[ST_OVERTEMP +: NCH];
  assign sh_f = stat_q[ST_SHORT +: NCH];
  assign offol_f = stat_q[ST_OFFOL +: NCH];
  assign onol_f = stat_q[ST_ONOL +: NCH];
  logic [NCH-1:0] on_q;
  logic [NCH-1:0] sh_set, offol_set, onol_set, led_tick;
  assign sh_set = s2_q.short_supply & ~sd_dis & ~on_q;
  assign offol_set = (s2_q.off_openload & ~offol_dis & ~on_q) | sh_set;
  assign onol_set = s2_q.on_lowcurrent & ~onol_dis & on_q
    & (~led_sel | led_tick);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= REG_RESET;
    end else if (s2_q.por) begin
      stat_q <= REG_RESET;
    end else begin
      stat_q[ST_OVERCUR +: NCH] <= s2_q.overcurrent | (ovc_f & ~{NCH{stat_rd}});
      stat_q[ST_OVERTEMP +: NCH] <= s2_q.overtemp | (ovt_f & ~{NCH{stat_rd}});
      stat_q[ST_SHORT +: NCH] <= sh_set
        | (sh_f & ~({NCH{stat_rd}} & ~s2_q.short_supply));
      stat_q[ST_OFFOL +: NCH] <= offol_set
        | (offol_f & ~({NCH{stat_rd}} & ~s2_q.off_openload & ~s2_q.short_supply));
      stat_q[ST_ONOL +: NCH] <= onol_set
        | (onol_f & ~({NCH{stat_rd}} & ~s2_q.on_lowcurrent));
      stat_q[ST_UNDERVOLT] <= s2_q.undervoltage | (stat_q[ST_UNDERVOLT] & ~stat_rd);
    end
  end

  // temperature prewarning in diagnostic register
  logic diag_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      diag_q <= 1'b0;
    end else if (s2_q.por) begin
      diag_q <= 1'b0;
    end else begin
      diag_q <= (s2_q.temp_warn && !s2_q.fail_safe) || (diag_q && !diag_rd);
    end
  end

  // led open-load check timer per output
  logic [$clog2(LEDCHK_CYC+1)-1:0] led_cnt_q [NCH];
  logic [NCH-1:0] retry_req;
  assign retry_req = s2_q.overcurrent | s2_q.overtemp | {NCH{s2_q.undervoltage}};

  // retry engine per output
  fdar_retry_e rst_q [NCH];
  logic [4:0] tries_q [NCH];
  logic [$clog2(RETRY_CYC+1)-1:0] rcnt_q [NCH];
  logic [NCH-1:0] inrush_q;

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    // led check tick: full duty, pwm on, on for a whole period
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        led_cnt_q[i] <= '0;
      end else if (!on_q[i] || pwm_duty != LED_FULL_DUTY || !gcr_q[GCR_PWM_EN]) begin
        led_cnt_q[i] <= '0;
      end else if (led_cnt_q[i] == ($clog2(LEDCHK_CYC+1))'(LEDCHK_CYC)) begin
        led_cnt_q[i] <= '0;
      end else begin
        led_cnt_q[i] <= led_cnt_q[i] + 1'b1;
      end
    end
    assign led_tick[i] = led_sel[i] && on_q[i]
      && led_cnt_q[i] == ($clog2(LEDCHK_CYC+1))'(LEDCHK_CYC);

    // autoretry state machine
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        rst_q[i] <= ST_IDLE;
        tries_q[i] <= 5'h00;
        rcnt_q[i] <= '0;
        inrush_q[i] <= 1'b0;
      end else if (sup_rst || (cmd[i] && !cmd_prev_q[i]) || !cmd[i]) begin
        rst_q[i] <= ST_IDLE;
        tries_q[i] <= 5'h00;
        rcnt_q[i] <= '0;
        inrush_q[i] <= cmd[i] && !cmd_prev_q[i];
      end else begin
        inrush_q[i] <= 1'b0;
        if (mode_chg) tries_q[i] <= 5'h00;
        case (rst_q[i])
          ST_IDLE: begin
            if (retry_req[i]) begin
              rst_q[i] <= ST_WAIT;
              rcnt_q[i] <= '0;
            end
          end
          ST_WAIT: begin
            if (rcnt_q[i] == ($clog2(RETRY_CYC+1))'(RETRY_CYC)) begin
              if (!mode_chg && tries_q[i] == RETRY_MAX) begin
                rst_q[i] <= ST_LATCHED;
              end else if (!retry_req[i]) begin
                rst_q[i] <= ST_TRY;
                if (!mode_chg) tries_q[i] <= tries_q[i] + 5'h01;
              end
            end else begin
              rcnt_q[i] <= rcnt_q[i] + 1'b1;
            end
          end
          ST_TRY: begin
            inrush_q[i] <= 1'b1;
            rst_q[i] <= ST_IDLE;
          end
          ST_LATCHED: rst_q[i] <= ST_LATCHED;
          default: rst_q[i] <= ST_IDLE;
        endcase
      end
    end

    // output drive
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        on_q[i] <= 1'b0;
      end else if (s2_q.clamp) begin
        on_q[i] <= 1'b1;
      end else if (!s2_q.logic_supply_ok) begin
        on_q[i] <= din_q[i] && s2_q.batt_ok && !retry_req[i];
      end else begin
        on_q[i] <= cmd[i] && rst_q[i] == ST_IDLE && !retry_req[i] && s2_q.batt_ok;
      end
    end
  end

  // fault pin (active high = fault), sense routing and switch/inrush outputs
  logic [4:0] sel_ch;
  assign sel_ch = 5'(gcr_q[GCR_CHSEL +: 2]);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_status_pin <= 1'b0;
      sense_output <= '0;
      switch_output <= '0;
      inrush_profile <= '0;
    end else begin
      fault_status_pin <= |(sh_set | s2_q.overcurrent | s2_q.overtemp)
        || s2_q.undervoltage;
      sense_output.temp_on <= gcr_q[GCR_TEMP_EN];
      sense_output.current_on <= gcr_q[GCR_SENSE_EN] && !gcr_q[GCR_TEMP_EN]
        && on_q[sel_ch[1:0]] && !s2_q.fail_safe;
      sense_output.channel <= sel_ch[1:0];
      sense_output.ratio <= ratio[sel_ch[1:0]];
      switch_output <= on_q;
      inrush_profile <= inrush_q;
    end
  end

  // read mux
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0000_0000;
    if (hit(haddr[7:0], OFF_CMD)) rd_d = cmd_q;
    if (hit(haddr[7:0], OFF_CFG)) rd_d = cfg_q;
    if (hit(haddr[7:0], OFF_GCR)) rd_d = gcr_q;
    if (hit(haddr[7:0], OFF_STAT)) rd_d = stat_q;
    if (hit(haddr[7:0], OFF_DIAG)) rd_d = {31'h0, diag_q};
    if (hit(haddr[7:0], OFF_LIVE)) rd_d = {8'h0, tries_q[3][3:0], tries_q[2][3:0],
      tries_q[1][3:0], tries_q[0][3:0], 4'h0, on_q};
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      if (take && !hwrite) hrdata <= rd_d;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // checks
  property p_ovc_read;
    @(posedge hclk) disable iff (!hresetn)
    (stat_rd && !s2_q.overcurrent[0] && !s2_q.por) |=> !stat_q[ST_OVERCUR];
  endproperty
  a_ovc_read: assert property (p_ovc_read) else $error("overcurrent flag not cleared");
  property p_short_hold;
    @(posedge hclk) disable iff (!hresetn)
    (stat_rd && !s2_q.por) |=> ((stat_q[ST_SHORT +: NCH] & $past(sh_f & s2_q.short_supply))
      == $past(sh_f & s2_q.short_supply));
  endproperty
  a_short_hold: assert property (p_short_hold) else $error("short flag lost");
  property p_clamp;
    @(posedge hclk) disable iff (!hresetn) s2_q.clamp |=> ##1 (switch_output == 4'hF);
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp not all on");
  property p_tries;
    @(posedge hclk) disable iff (!hresetn) tries_q[0] <= RETRY_MAX;
  endproperty
  a_tries: assert property (p_tries) else $error("too many retries");
  property p_por;
    @(posedge hclk) disable iff (!hresetn) s2_q.por |=> (stat_q == 32'h0 && cmd_q == 32'h0);
  endproperty
  a_por: assert property (p_por) else $error("por did not clear");
  property p_latched;
    @(posedge hclk) disable iff (!hresetn)
    (rst_q[0] == ST_LATCHED && !s2_q.clamp && s2_q.logic_supply_ok) |=> !on_q[0];
  endproperty
  a_latched: assert property (p_latched) else $error("latched output on");
  property p_sense;
    @(posedge hclk) disable iff (!hresetn) s2_q.fail_safe |=> !sense_output.current_on;
  endproperty
  a_sense: assert property (p_sense) else $error("sense in fail-safe");
  property p_short_dis;
    @(posedge hclk) disable iff (!hresetn)
    (|(sd_dis & ~sh_f)) |=> ((stat_q[ST_SHORT +: NCH] & $past(sd_dis & ~sh_f)) == 4'h0);
  endproperty
  a_short_dis: assert property (p_short_dis) else $error("disabled short set");
  property p_retry_off;
    @(posedge hclk) disable iff (!hresetn)
    (retry_req[0] && !s2_q.clamp) |=> !on_q[0];
  endproperty
  a_retry_off: assert property (p_retry_off) else $error("output on during retry");
  property p_inrush;
    @(posedge hclk) disable iff (!hresetn)
    (rst_q[0] == ST_TRY && cmd[0] && cmd_prev_q[0] && !sup_rst) |=> inrush_q[0];
  endproperty
  a_inrush: assert property (p_inrush) else $error("retry without inrush profile");
  property p_offol_set;
    @(posedge hclk) disable iff (!hresetn)
    (s2_q.off_openload[2] && !offol_dis[2] && !on_q[2] && !s2_q.por) |=> stat_q[ST_OFFOL + 2];
  endproperty
  a_offol_set: assert property (p_offol_set) else $error("off open load missed");
  property p_led_quiet;
    @(posedge hclk) disable iff (!hresetn)
    (led_sel[2] && !led_tick[2] && !onol_f[2] && !s2_q.por) |=> !stat_q[ST_ONOL + 2];
  endproperty
  a_led_quiet: assert property (p_led_quiet) else $error("led flag off check");
  property p_diag_set;
    @(posedge hclk) disable iff (!hresetn)
    (s2_q.temp_warn && !s2_q.fail_safe && !s2_q.por) |=> diag_q;
  endproperty
  a_diag_set: assert property (p_diag_set) else $error("prewarning not latched");
  property p_sense_off;
    @(posedge hclk) disable iff (!hresetn)
    !on_q[sel_ch[1:0]] |=> !sense_output.current_on;
  endproperty
  a_sense_off: assert property (p_sense_off) else $error("sense while switch off");
endmodule

//--- tb/fdar_host.sv
`timescale 1ns/1ps
// ahb-lite master standing in for the host controller
module fdar_host (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // bus idle at time zero, word transfers only
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // one single transfer, each phase held until hready is seen high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata; // read data taken at the closing edge
  endtask
endmodule

//--- tb/fault_diag_autoretry_tb.sv
`timescale 1ns/1ps
module fault_diag_autoretry_tb;
  import fdar_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hready, hreadyout, hresp, fault_status_pin, inrush_seen;
  logic [31:0] haddr, hwdata, hrdata, q, v, seed;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] direct_in = 4'h0;
  logic [7:0] pwm_duty = 8'hFF;
  logic [3:0] switch_output, inrush_profile;
  logic [7:0] offs [7] = '{OFF_CMD, OFF_CFG, OFF_GCR, OFF_STAT, OFF_DIAG, OFF_LIVE, 8'h20};
  fdar_sense_s si;
  fdar_route_s sense_output;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;

  // clock and single slave hready
  always #2 hclk = ~hclk;
  assign hready = hreadyout;

  fdar_host host (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  fdar_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sense_in(si), .direct_in(direct_in),
    .pwm_duty(pwm_duty), .switch_output(switch_output), .inrush_profile(inrush_profile),
    .fault_status_pin(fault_status_pin), .sense_output(sense_output));

  // next random value
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected per-output status group
  function automatic logic [31:0] sbit(input int pos, input logic [3:0] m);
    return {28'h0000000, m} << pos;
  endfunction

  task automatic end_of_test;
    if (errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic w(input int k);
    repeat (k) @(posedge hclk);
  endtask

  // hang guard and turn-on pulse watch
  always @(posedge hclk) begin
    cyc++;
    if (inrush_profile[0] === 1'b1) inrush_seen <= 1'b1;
    if (cyc == 60000) begin
      errors++;
      end_of_test();
    end
  end

  initial begin
    seed = 32'h0000_0037;
    inrush_seen = 1'b0;
    si = '0;
    si.logic_supply_ok = 1'b1;
    si.batt_ok = 1'b1;
    w(5);
    hresetn <= 1'b1;
    // reset values, unmapped word reads zero
    foreach (offs[i]) rd(offs[i], REG_RESET);
    for (n = 0; n < 4; n++) begin
      seed = lfsr(seed);
      v = seed & 32'h000F_FFFF;
      wr(OFF_CFG, v);
      rd(OFF_CFG, v);
      wr(OFF_GCR, v & 32'h0000_003F);
      rd(OFF_GCR, v & 32'h0000_003F);
    end
    wr(8'h20, seed);
    rd(8'h20, 32'h0000_0000);
    wr(OFF_CFG, 32'h0000_0000);
    wr(OFF_GCR, 32'h0000_0000);
    // short on an off output
    si.short_supply <= 4'h2;
    w(6);
    chk(32'(fault_status_pin), 32'h0000_0001);
    rd(OFF_STAT, sbit(ST_SHORT, 4'h2) | sbit(ST_OFFOL, 4'h2));
    rd(OFF_STAT, sbit(ST_SHORT, 4'h2) | sbit(ST_OFFOL, 4'h2));
    si.short_supply <= 4'h0;
    w(6);
    rd(OFF_STAT, sbit(ST_SHORT, 4'h2) | sbit(ST_OFFOL, 4'h2));
    rd(OFF_STAT, 32'h0000_0000);
    // disables suppress detection, then off open load latches
    wr(OFF_CFG, 32'h0000_0042);
    si.short_supply <= 4'h2;
    si.off_openload <= 4'h4;
    w(6);
    rd(OFF_STAT, 32'h0000_0000);
    wr(OFF_CFG, 32'h0000_0002);
    w(6);
    rd(OFF_STAT, sbit(ST_OFFOL, 4'h4));
    si.short_supply <= 4'h0;
    si.off_openload <= 4'h0;
    w(6);
    rd(OFF_STAT, sbit(ST_OFFOL, 4'h4));
    rd(OFF_STAT, 32'h0000_0000);
    // prewarning latched until read
    si.temp_warn <= 1'b1;
    w(6);
    si.temp_warn <= 1'b0;
    w(6);
    rd(OFF_DIAG, 32'h0000_0001);
    rd(OFF_DIAG, 32'h0000_0000);
    // outputs on, sense routing
    wr(OFF_GCR, 32'h0000_000A);
    wr(OFF_CMD, 32'h0000_000F);
    w(6);
    chk(32'(switch_output), 32'h0000_000F);
    chk(32'(sense_output.current_on), 32'h0000_0001);
    chk(32'(sense_output), 32'h0000_0014);
    chk(32'(hresp), 32'h0000_0000);
    si.fail_safe <= 1'b1;
    w(6);
    chk(32'(sense_output.current_on), 32'h0000_0000);
    si.fail_safe <= 1'b0;
    // low on-current flags only
    si.on_lowcurrent <= 4'h4;
    w(6);
    chk(32'(switch_output), 32'h0000_000F);
    chk(32'(fault_status_pin), 32'h0000_0000);
    si.on_lowcurrent <= 4'h0;
    w(6);
    rd(OFF_STAT, sbit(ST_ONOL, 4'h4));
    rd(OFF_STAT, 32'h0000_0000);
    // led open load seen only at the periodic full-duty check
    wr(OFF_CFG, 32'h0000_4002);
    wr(OFF_GCR, 32'h0000_001A);
    pwm_duty <= 8'h7F;
    si.on_lowcurrent <= 4'h4;
    w(100);
    rd(OFF_STAT, 32'h0000_0000);
    pwm_duty <= 8'hFF;
    w(LEDCHK_CYC + 20);
    si.on_lowcurrent <= 4'h0;
    w(6);
    rd(OFF_STAT, sbit(ST_ONOL, 4'h4));
    rd(OFF_STAT, 32'h0000_0000);
    wr(OFF_CFG, 32'h0000_0002);
    wr(OFF_GCR, 32'h0000_000A);
    // overcurrent, read clear, one retry
    si.overcurrent <= 4'h1;
    w(3);
    si.overcurrent <= 4'h0;
    w(6);
    chk(32'(switch_output), 32'h0000_000E);
    rd(OFF_STAT, sbit(ST_OVERCUR, 4'h1));
    inrush_seen <= 1'b0;
    n = 0;
    while (switch_output[0] !== 1'b1 && n < RETRY_CYC + 1000) begin
      w(1);
      n++;
    end
    w(2);
    chk(32'(switch_output), 32'h0000_000F);
    chk(32'(inrush_seen), 32'h0000_0001);
    host.xfer(1'b0, OFF_LIVE, 32'h0000_0000, q);
    chk(q & 32'h00FF_FF00, 32'h0000_0100);
    si.fail_safe <= 1'b1;
    w(6);
    si.fail_safe <= 1'b0;
    w(6);
    host.xfer(1'b0, OFF_LIVE, 32'h0000_0000, q);
    chk(q & 32'h00FF_FF00, 32'h0000_0000);
    // clamp forces all on
    wr(OFF_CMD, 32'h0000_0000);
    w(6);
    si.clamp <= 1'b1;
    w(6);
    chk(32'(switch_output), 32'h0000_000F);
    si.clamp <= 1'b0;
    w(6);
    // no logic supply: direct inputs drive
    seed = lfsr(seed);
    direct_in <= seed[3:0];
    si.logic_supply_ok <= 1'b0;
    w(6);
    chk(32'(switch_output), 32'(seed[3:0]));
    si.logic_supply_ok <= 1'b1;
    w(6);
    rd(OFF_GCR, 32'h0000_000A);
    // battery loss keeps config, reports undervoltage
    wr(OFF_CFG, 32'h0000_1234);
    si.batt_ok <= 1'b0;
    si.undervoltage <= 1'b1;
    w(6);
    rd(OFF_CFG, 32'h0000_1234);
    rd(OFF_STAT, 32'h0010_0000);
    si.batt_ok <= 1'b1;
    si.undervoltage <= 1'b0;
    // supply fail with enable clears registers
    wr(OFF_GCR, 32'h0000_0020);
    si.logic_supply_ok <= 1'b0;
    w(6);
    si.logic_supply_ok <= 1'b1;
    w(6);
    rd(OFF_CFG, 32'h0000_0000);
    rd(OFF_GCR, 32'h0000_0000);
    // power-on reset clears all
    wr(OFF_CFG, 32'h0000_0055);
    si.por <= 1'b1;
    w(6);
    si.por <= 1'b0;
    w(6);
    rd(OFF_CFG, 32'h0000_0000);
    rd(OFF_STAT, 32'h0000_0000);
    end_of_test();
  end
endmodule
